// ===== rtl/cgtc_pkg.sv
// package: register map and field layout of the channel gain/threshold bank
package cgtc_pkg;

	// ---------------------------------------------------------------
	// register map (byte offsets, one 32-bit word per slice)
	// ---------------------------------------------------------------
	localparam logic [5:0] GAIN_LO_W0_OFS = 6'h00;
	localparam logic [5:0] GAIN_LO_W1_OFS = 6'h04;
	localparam logic [5:0] GAIN_HI_W0_OFS = 6'h08;
	localparam logic [5:0] GAIN_HI_W1_OFS = 6'h0c;
	localparam logic [5:0] THR_LO_W0_OFS  = 6'h10;
	localparam logic [5:0] THR_LO_W3_OFS  = 6'h1c;
	localparam logic [5:0] ID_OFS         = 6'h20;

	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam int          GAIN_BITS   = 64;
	localparam int          THR_BITS    = 128;
	localparam int          GAIN_FIELD  = 2;
	localparam int          THR_FIELD   = 4;
	localparam int          CH_PER_REG  = 32;
	localparam logic [63:0]  GAIN_RST   = 64'h0;
	localparam logic [127:0] THR_RST    = 128'h0;
	// arbitrary neutral identity value
	localparam logic [31:0] ID_VALUE    = 32'h0000_00a5;

	// charge range codes (msb, lsb)
	typedef enum logic [1:0] {
		CGTC_RANGE_120FC = 2'h0,
		CGTC_RANGE_240FC = 2'h1,
		CGTC_RANGE_1PC   = 2'h2,
		CGTC_RANGE_10PC  = 2'h3
	} cgtc_range_type;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-channel analog selects, index 0 is channel 1
	typedef struct packed {
		cgtc_range_type [63:0] range;
		logic [31:0][3:0]      level;
	} cgtc_chan_type;

endpackage

// ===== rtl/cgtc_regs.sv
// file: AXI4-Lite register bank holding per-channel gain and threshold codes
`timescale 1ns/1ps
module cgtc_regs
	import cgtc_pkg::*;
(
	// clock, reset, enable
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire logic          clk_en,
	// axi4-lite write address and data
	input  wire logic [5:0]    awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	// axi4-lite write response
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	// axi4-lite read
	input  wire logic [5:0]    araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	// analog selects
	output cgtc_chan_type      chan_cfg
);

	// ---------------------------------------------------------------
	// storage: four 32-bit slices per 128 bits of gain, four of threshold
	// ---------------------------------------------------------------
	logic [63:0]    gain_lo_q;
	logic [63:0]    gain_hi_q;
	logic [127:0]   thr_lo_q;
	logic [5:0]     aw_q;
	logic           aw_have_q;
	logic [31:0]    w_q;
	logic [3:0]     ws_q;
	logic           w_have_q;
	logic [255:0]   bank_q;
	cgtc_chan_type  chan_q;

	// word index of a byte address within the bank
	function automatic logic [3:0] word_idx(input logic [5:0] a);
		return a[5:2];
	endfunction

	// strobe merge of one word
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire logic       do_write  = aw_have_q && w_have_q && !bvalid;
	wire logic [3:0] wr_idx    = word_idx(aw_q);
	wire logic       wr_hit    = (aw_q[1:0] == 2'h0) && (aw_q <= THR_LO_W3_OFS);
	wire logic [3:0] rd_idx    = word_idx(araddr);
	wire logic       rd_bank   = (araddr[1:0] == 2'h0) && (araddr <= THR_LO_W3_OFS);
	wire logic       rd_id     = (araddr == ID_OFS);
	wire logic       take_rd   = arvalid && arready;
	assign bank_q = {thr_lo_q, gain_hi_q, gain_lo_q};

	// ---------------------------------------------------------------
	// write channel capture: address and data taken in either order
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_q      <= 6'h0;
			aw_have_q <= 1'b0;
			w_q       <= 32'h0;
			ws_q      <= 4'h0;
			w_have_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
		end else if (clk_en) begin
			awready <= !aw_have_q && !awready && !awvalid ? 1'b1 : (!aw_have_q && !awready);
			wready  <= !w_have_q && !wready;
			if (awvalid && awready) begin
				aw_q      <= awaddr;
				aw_have_q <= 1'b1;
				awready   <= 1'b0;
			end
			if (wvalid && wready) begin
				w_q      <= wdata;
				ws_q     <= wstrb;
				w_have_q <= 1'b1;
				wready   <= 1'b0;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// register store and write response
	// ---------------------------------------------------------------
	// gain and threshold storage
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gain_lo_q <= GAIN_RST;
			gain_hi_q <= GAIN_RST;
			thr_lo_q  <= THR_RST;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else if (clk_en) begin
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			// refused or unaligned addresses answer but store nothing
			if (do_write && wr_hit) begin
				unique case (wr_idx[3:1])
					3'h0: gain_lo_q[32*wr_idx[0] +: 32] <=
						merge(gain_lo_q[32*wr_idx[0] +: 32], w_q, ws_q);
					3'h1: gain_hi_q[32*wr_idx[0] +: 32] <=
						merge(gain_hi_q[32*wr_idx[0] +: 32], w_q, ws_q);
					3'h2, 3'h3: thr_lo_q[32*wr_idx[1:0] +: 32] <=
						merge(thr_lo_q[32*wr_idx[1:0] +: 32], w_q, ws_q);
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// read channel: one outstanding read, answer the cycle after address
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			arready <= !rvalid && !arready && !take_rd;
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			if (take_rd) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_bank ? bank_q[32*rd_idx[2:0] +: 32] : (rd_id ? ID_VALUE : 32'h0);
				rresp   <= (rd_bank || rd_id) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ---------------------------------------------------------------
	// per-channel fan-out to analog selects
	// ---------------------------------------------------------------
	cgtc_chan_type chan_d;
	genvar c;
	generate
		for (c = 0; c < CH_PER_REG; c++) begin : g_ch
			// codes map directly to range enum
			// channel c+1 low gain at bits 63-2c
			assign chan_d.range[c] = cgtc_range_type'(gain_lo_q[GAIN_BITS-GAIN_FIELD*(c+1) +: 2]);
			assign chan_d.range[c+CH_PER_REG] = cgtc_range_type'(gain_hi_q[GAIN_FIELD*c +: 2]);
			// channel c+1 threshold at bits 127-4c down
			assign chan_d.level[c] = thr_lo_q[THR_BITS-THR_FIELD*(c+1) +: 4];
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_q <= '0;
		end else if (clk_en) begin
			chan_q <= chan_d;
		end
	end
	assign chan_cfg = chan_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	ch1_gain_map_a: assert property (clk_en |=> chan_cfg.range[0] == $past(gain_lo_q[63:62]))
		else $error("channel 1 gain not from bits 63:62");
	ch32_gain_map_a: assert property (clk_en |=> chan_cfg.range[31] == $past(gain_lo_q[1:0]))
		else $error("channel 32 gain not from bits 1:0");
	ch33_gain_map_a: assert property (clk_en |=> chan_cfg.range[32] == $past(gain_hi_q[1:0]))
		else $error("channel 33 gain not from bits 1:0");
	ch64_gain_map_a: assert property (clk_en |=> chan_cfg.range[63] == $past(gain_hi_q[63:62]))
		else $error("channel 64 gain not from bits 63:62");
	ch1_thr_map_a: assert property (clk_en |=> chan_cfg.level[0] == $past(thr_lo_q[127:124]))
		else $error("channel 1 threshold not from bits 127:124");
	ch32_thr_map_a: assert property (clk_en |=> chan_cfg.level[31] == $past(thr_lo_q[3:0]))
		else $error("channel 32 threshold not from bits 3:0");
	range_code_a: assert property (chan_cfg.range[5] == CGTC_RANGE_10PC |->
		$past(gain_lo_q[53:52]) == 2'h3 || !$past(clk_en))
		else $error("range code mismatch");
	hold_no_write_a: assert property (!do_write && !$past(do_write) |=> $stable(thr_lo_q))
		else $error("threshold changed without a write");

	// write path: both halves held, then response raised
	sequence pair_held_s;
		clk_en && aw_have_q && w_have_q && !bvalid;
	endsequence
	sequence resp_up_s;
		bvalid;
	endsequence
	wr_resp_a: assert property (pair_held_s |=> resp_up_s)
		else $error("write response not raised after address and data");
	refuse_store_a: assert property (clk_en && do_write && !wr_hit |=>
		$stable(gain_lo_q) && $stable(gain_hi_q) && $stable(thr_lo_q))
		else $error("refused write changed a register");
	bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped before it was taken");
	rd_resp_a: assert property (clk_en && take_rd |=> rvalid)
		else $error("read answer missing after address taken");
	freeze_hold_a: assert property (!clk_en |=> $stable(chan_cfg) &&
		$stable(awready) && $stable(wready) && $stable(arready))
		else $error("state moved while clock enable low");

endmodule

// ===== testbench/tb.sv
// testbench: bus access, field mapping and refusal checks for the gain/threshold bank
`timescale 1ns/1ps
module tb import cgtc_pkg::*;;
	logic          sys_clk, arst_n, clk_en, awvalid, wvalid, bready, arvalid, rready;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [5:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, r;
	cgtc_chan_type chan_cfg;
	logic [63:0]   g_lo, g_hi;
	logic [127:0]  thr;
	int            fail_count, checks_done;

	cgtc_regs cgtc_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .chan_cfg(chan_cfg));

	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task chk(input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// axi4-lite write, address and data released independently
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
		bit ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (awvalid && awready) begin ad = 1; awvalid <= 1'b0; end
			if (wvalid && wready) begin wd = 1; wvalid <= 1'b0; end
		end
		bready <= 1'b1;
		do @(posedge sys_clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		araddr <= a; arvalid <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0; rready <= 1'b1;
		do @(posedge sys_clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// every channel output against the expected registers
	task chk_cfg;
		repeat (2) @(posedge sys_clk);
		for (int c = 1; c <= 32; c++) begin
			chk(chan_cfg.range[c-1], g_lo[2*(32-c) +: 2]);
			chk(chan_cfg.range[c+31], g_hi[2*(c-1) +: 2]);
			chk(chan_cfg.level[c-1], thr[4*(32-c) +: 4]);
		end
	endtask

	task t_regs;
		logic [255:0] wv;
		logic [31:0]  d;
		g_lo = 64'hd8b4_1e27_93c6_5af1;
		g_hi = 64'h2c7e_91b3_06da_4f58;
		thr  = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
		wv = {thr, g_hi, g_lo};
		for (int i = 0; i < 8; i++) begin
			wr(6'(4*i), wv[32*i +: 32], 4'hf);
			chk(r, RESP_OKAY);
		end
		chk_cfg;
		for (int i = 0; i < 8; i++) begin
			rd(6'(4*i), d);
			chk(d, wv[32*i +: 32]);
		end
		$display("test regs done");
	endtask

	// all four range codes, single byte strobe
	task t_codes;
		cgtc_range_type codes [4];
		codes = '{CGTC_RANGE_120FC, CGTC_RANGE_240FC, CGTC_RANGE_1PC, CGTC_RANGE_10PC};
		for (int k = 0; k < 4; k++) begin
			wr(GAIN_LO_W0_OFS, {30'h3fff_fff0, 2'(k)}, 4'h1);
			g_lo[7:0] = {6'h30, 2'(k)};
			chk_cfg;
			chk(chan_cfg.range[31], codes[k]);
		end
		$display("test codes done");
	endtask

	task t_err;
		logic [31:0] d;
		wr(6'h24, 32'hffff_ffff, 4'hf);
		chk(r, RESP_SLVERR);
		wr(6'h02, 32'hffff_ffff, 4'hf);
		chk(r, RESP_SLVERR);
		rd(6'h2c, d);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		wr(ID_OFS, 32'hffff_ffff, 4'hf);
		chk(r, RESP_SLVERR);
		rd(ID_OFS, d);
		chk({r, d}, {RESP_OKAY, ID_VALUE});
		rd(6'h05, d);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		chk_cfg;
		$display("test err done");
	endtask

	// clock enable low freezes every flop, idle ready toggling included
	task t_freeze;
		logic [4:0] held;
		clk_en <= 1'b0;
		@(posedge sys_clk);
		held = {awready, wready, arready, bvalid, rvalid};
		repeat (3) @(posedge sys_clk);
		chk({awready, wready, arready, bvalid, rvalid}, held);
		clk_en <= 1'b1;
		chk_cfg;
		$display("test freeze done");
	endtask

	// mid-run reset returns every field to its reset value
	task t_reset;
		logic [31:0] d;
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		g_lo = GAIN_RST;
		g_hi = GAIN_RST;
		thr  = THR_RST;
		chk_cfg;
		rd(THR_LO_W3_OFS, d);
		chk(d, THR_RST[127:96]);
		$display("test reset done");
	endtask

	initial begin
		clk_en <= 1'b1; arst_n <= 1'b0; awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0;
		arvalid <= 1'b0; rready <= 1'b0; awaddr <= 6'h00; araddr <= 6'h00;
		wdata <= 32'h0; wstrb <= 4'h0;
		g_lo = 64'h0; g_hi = 64'h0; thr = 128'h0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		chk_cfg;
		t_regs;
		t_codes;
		t_err;
		t_freeze;
		t_reset;
		wrap_up;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		wrap_up;
	end
endmodule
